// [logic/emt_pkg.sv]
package emt_pkg;

	// ----------------------------------------
	// Register map (printed offsets are byte addresses, low 16 bits)
	// ----------------------------------------
	localparam logic [15:0] TIMER_CONTROL_ADDR        = 16'hffd0;
	localparam logic [15:0] TIMER_CONTROL_STATUS_ADDR = 16'hffd1;
	localparam logic [15:0] MATCH_CONSTANT_A_ADDR     = 16'hffd2;
	localparam logic [15:0] MATCH_CONSTANT_B_ADDR     = 16'hffd3;
	localparam logic [15:0] TICK_COUNTER_ADDR         = 16'hffd4;
	localparam logic [15:0] STANDBY_ADDR              = 16'hffd8;

	// ----------------------------------------
	// Reset values and counter maximum
	// ----------------------------------------
	localparam logic [7:0] TIMER_CONTROL_RST    = 8'h00;
	localparam logic [7:0] STATUS_FIXED_BITS    = 8'h10;
	localparam logic [7:0] MATCH_CONSTANT_RST   = 8'hff;
	localparam logic [7:0] TICK_COUNTER_RST     = 8'h00;
	localparam logic [7:0] COUNTER_MAX          = 8'hff;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_MATCH_B_IE_POS = 7;
	localparam int CTL_MATCH_A_IE_POS = 6;
	localparam int CTL_WRAP_IE_POS    = 5;
	localparam int CTL_CLR_SEL_LSB    = 3;
	localparam int CTL_CLK_SEL_LSB    = 0;
	localparam int STS_MATCH_B_POS    = 7;
	localparam int STS_MATCH_A_POS    = 6;
	localparam int STS_WRAP_POS       = 5;
	localparam int STS_ACT_B_LSB      = 2;
	localparam int STS_ACT_A_LSB      = 0;

	// ----------------------------------------
	// Prescaler divide ratios
	// ----------------------------------------
	localparam int DIV_SLOW   = 8;
	localparam int DIV_MEDIUM = 64;
	localparam int DIV_LONG   = 1024;
	localparam int PRESCALE_W = 10;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		CLK_STOP0    = 3'h0,
		CLK_DIV8     = 3'h1,
		CLK_DIV64    = 3'h2,
		CLK_DIV1024  = 3'h3,
		CLK_STOP4    = 3'h4,
		CLK_EXT_RISE = 3'h5,
		CLK_EXT_FALL = 3'h6,
		CLK_EXT_BOTH = 3'h7
	} emt_clk_sel_t;

	typedef enum logic [1:0] {
		CLR_NONE    = 2'h0,
		CLR_MATCH_A = 2'h1,
		CLR_MATCH_B = 2'h2,
		CLR_EXT     = 2'h3
	} emt_clr_sel_t;

	typedef enum logic [1:0] {
		ACT_KEEP   = 2'h0,
		ACT_LOW    = 2'h1,
		ACT_HIGH   = 2'h2,
		ACT_TOGGLE = 2'h3
	} emt_out_act_t;

	// Interrupt request group toward the interrupt controller
	typedef struct packed {
		logic match_b_irq;
		logic match_a_irq;
		logic wrap_irq;
	} emt_irq_t;

	// Service acknowledges from the transfer controller
	typedef struct packed {
		logic match_b_ack;
		logic match_a_ack;
	} emt_xfer_ack_t;

endpackage

// [logic/emt_timer.sv]
`timescale 1ns/1ps

module emt_timer (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_sys_rst,
	input  wire logic                  i_standby,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [15:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  i_external_count_input,
	input  wire logic                  i_external_clear_input,
	input  wire emt_pkg::emt_xfer_ack_t i_xfer_ack,
	output emt_pkg::emt_irq_t          o_irq,
	output logic                       o_wave_output,
	output logic                       o_wave_output_en
);
	import emt_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]            timer_control;
	logic [7:0]            match_constant_a;
	logic [7:0]            match_constant_b;
	logic [7:0]            tick_counter;
	logic                  match_a_flag;
	logic                  match_b_flag;
	logic                  wrap_flag;
	logic [3:0]            out_action;
	logic [2:0]            armed;
	logic [PRESCALE_W-1:0] prescale;
	logic                  ext_cnt_q;
	logic                  ext_clr_q;
	logic                  step_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic         access;
	logic         wr;
	logic         rd;
	logic         hit_ctl;
	logic         hit_sts;
	logic         hit_cora;
	logic         hit_corb;
	logic         hit_cnt;
	logic         hit_stby;
	logic         mapped;
	logic [7:0]   status_rd;
	emt_clk_sel_t clk_sel;
	emt_clr_sel_t clr_sel;

	assign access   = psel & penable;
	assign wr       = access & pwrite;
	assign rd       = access & ~pwrite;
	assign hit_ctl  = (paddr == TIMER_CONTROL_ADDR);
	assign hit_sts  = (paddr == TIMER_CONTROL_STATUS_ADDR);
	assign hit_cora = (paddr == MATCH_CONSTANT_A_ADDR);
	assign hit_corb = (paddr == MATCH_CONSTANT_B_ADDR);
	assign hit_cnt  = (paddr == TICK_COUNTER_ADDR);
	assign hit_stby = (paddr == STANDBY_ADDR);
	assign mapped   = hit_ctl | hit_sts | hit_cora | hit_corb | hit_cnt | hit_stby;
	assign clk_sel  = emt_clk_sel_t'(timer_control[CTL_CLK_SEL_LSB +: 3]);
	assign clr_sel  = emt_clr_sel_t'(timer_control[CTL_CLR_SEL_LSB +: 2]);

	always_comb begin
		status_rd                  = STATUS_FIXED_BITS;
		status_rd[STS_MATCH_B_POS] = match_b_flag;
		status_rd[STS_MATCH_A_POS] = match_a_flag;
		status_rd[STS_WRAP_POS]    = wrap_flag;
		status_rd[3:0]             = out_action;
	end

	// ----------------------------------------
	// Count pulse generation
	// ----------------------------------------
	logic ext_rise;
	logic ext_fall;
	logic step;

	assign ext_rise = i_external_count_input & ~ext_cnt_q;
	assign ext_fall = ~i_external_count_input & ext_cnt_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			prescale  <= '0;
			ext_cnt_q <= 1'b0;
			ext_clr_q <= 1'b0;
		end else begin
			prescale  <= prescale + 1'b1;
			ext_cnt_q <= i_external_count_input;
			ext_clr_q <= i_external_clear_input;
		end
	end

	always_comb begin
		case (clk_sel)
			CLK_DIV8:     step = (prescale[$clog2(DIV_SLOW)-1:0] == '1);
			CLK_DIV64:    step = (prescale[$clog2(DIV_MEDIUM)-1:0] == '1);
			CLK_DIV1024:  step = (prescale[$clog2(DIV_LONG)-1:0] == '1);
			CLK_EXT_RISE: step = ext_rise;
			CLK_EXT_FALL: step = ext_fall;
			CLK_EXT_BOTH: step = ext_rise | ext_fall;
			default:      step = 1'b0;
		endcase
	end

	// Matches are signalled on the last cycle the count holds the value,
	// i.e. when the next count pulse arrives.
	// compare qualified by the count pulse
	logic match_a;
	logic match_b;
	logic ext_clr;
	logic do_clear;
	logic wrap;

	assign match_a  = step & (tick_counter == match_constant_a);
	assign match_b  = step & (tick_counter == match_constant_b);
	assign ext_clr  = i_external_clear_input & ~ext_clr_q;
	assign do_clear = ((clr_sel == CLR_MATCH_A) & match_a) |
	                  ((clr_sel == CLR_MATCH_B) & match_b) |
	                  ((clr_sel == CLR_EXT) & ext_clr);
	assign wrap     = step & ~do_clear & (tick_counter == COUNTER_MAX);

	always_ff @(posedge i_clk_sys) begin
		step_q <= i_sys_rst ? 1'b0 : step;
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_standby) begin
			tick_counter <= TICK_COUNTER_RST;
		end else if (wr && hit_cnt) begin
			tick_counter <= pwdata[7:0];
		end else if (do_clear) begin
			tick_counter <= TICK_COUNTER_RST;
		end else if (step) begin
			tick_counter <= tick_counter + 8'h01;
		end
	end

	// ----------------------------------------
	// Control and constants
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_standby) begin
			timer_control    <= TIMER_CONTROL_RST;
			match_constant_a <= MATCH_CONSTANT_RST;
			match_constant_b <= MATCH_CONSTANT_RST;
			out_action       <= 4'h0;
		end else if (wr) begin
			if (hit_ctl) begin
				timer_control <= pwdata[7:0];
			end else if (hit_cora) begin
				match_constant_a <= pwdata[7:0];
			end else if (hit_corb) begin
				match_constant_b <= pwdata[7:0];
			end else if (hit_sts) begin
				out_action <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Arming bits remember a flag seen as one by a status read; a zero
	// write only clears an armed flag. A set in the same cycle wins.
	logic sts_wr;
	logic sts_rd;

	assign sts_wr = wr & hit_sts;
	assign sts_rd = rd & hit_sts;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_standby) begin
			match_b_flag <= 1'b0;
			match_a_flag <= 1'b0;
			wrap_flag    <= 1'b0;
			armed        <= 3'h0;
		end else begin
			if (match_b) begin
				match_b_flag <= 1'b1;
			end else if (i_xfer_ack.match_b_ack) begin
				match_b_flag <= 1'b0;
			end else if (sts_wr && armed[2] && !pwdata[STS_MATCH_B_POS]) begin
				match_b_flag <= 1'b0;
			end
			if (match_a) begin
				match_a_flag <= 1'b1;
			end else if (i_xfer_ack.match_a_ack) begin
				match_a_flag <= 1'b0;
			end else if (sts_wr && armed[1] && !pwdata[STS_MATCH_A_POS]) begin
				match_a_flag <= 1'b0;
			end
			if (wrap) begin
				wrap_flag <= 1'b1;
			end else if (sts_wr && armed[0] && !pwdata[STS_WRAP_POS]) begin
				wrap_flag <= 1'b0;
			end
			// arming on read of a one
			if (sts_rd) begin
				armed <= {match_b_flag, match_a_flag, wrap_flag};
			end else if (sts_wr) begin
				armed <= 3'h0;
			end
		end
	end

	// ----------------------------------------
	// Interrupt requests
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_irq <= '0;
		end else begin
			o_irq.match_b_irq <= match_b_flag & timer_control[CTL_MATCH_B_IE_POS];
			o_irq.match_a_irq <= match_a_flag & timer_control[CTL_MATCH_A_IE_POS];
			o_irq.wrap_irq    <= wrap_flag & timer_control[CTL_WRAP_IE_POS];
		end
	end

	// ----------------------------------------
	// Waveform output
	// ----------------------------------------
	emt_out_act_t act_a;
	emt_out_act_t act_b;

	assign act_a = emt_out_act_t'(out_action[STS_ACT_A_LSB +: 2]);
	assign act_b = emt_out_act_t'(out_action[STS_ACT_B_LSB +: 2]);

	// When both matches fall in one cycle, match B's action is taken unless it is keep, in which case match A's is.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_standby) begin
			o_wave_output    <= 1'b0;
			o_wave_output_en <= 1'b0;
		end else begin
			// not driven when all actions keep
			o_wave_output_en <= (out_action != 4'h0);
			if (match_b && act_b != ACT_KEEP) begin
				o_wave_output <= (act_b == ACT_TOGGLE) ? ~o_wave_output : (act_b == ACT_HIGH);
			end else if (match_a && act_a != ACT_KEEP) begin
				o_wave_output <= (act_a == ACT_TOGGLE) ? ~o_wave_output : (act_a == ACT_HIGH);
			end
		end
	end

	// ----------------------------------------
	// APB slave: zero wait states
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel && !penable && !pwrite) begin
				if (hit_ctl) begin
					prdata <= {24'h000000, timer_control};
				end else if (hit_sts) begin
					prdata <= {24'h000000, status_rd};
				end else if (hit_cora) begin
					prdata <= {24'h000000, match_constant_a};
				end else if (hit_corb) begin
					prdata <= {24'h000000, match_constant_b};
				end else if (hit_cnt) begin
					prdata <= {24'h000000, tick_counter};
				end else if (hit_stby) begin
					prdata <= {31'h00000000, i_standby};
				end else begin
					prdata <= 32'h0000_0000;
				end
			end
		end
	end

endmodule

// [tb/emt_timer_properties.sv]
`timescale 1ns/1ps
module emt_timer_properties (
	input wire logic             i_clk_sys,
	input wire logic             i_sys_rst,
	input wire logic             i_standby,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [15:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire emt_pkg::emt_irq_t o_irq,
	input wire logic             o_wave_output_en
);
	import emt_pkg::*;

	logic [7:0] ctl_sh;
	logic       mapped;

	assign mapped = paddr inside {TIMER_CONTROL_ADDR, TIMER_CONTROL_STATUS_ADDR, MATCH_CONSTANT_A_ADDR,
		MATCH_CONSTANT_B_ADDR, TICK_COUNTER_ADDR, STANDBY_ADDR};

	// Shadow of the enables; standby wipes it just as it wipes the real one
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_standby) begin
			ctl_sh <= TIMER_CONTROL_RST;
		end else if (psel && penable && pready && pwrite && paddr == TIMER_CONTROL_ADDR) begin
			ctl_sh <= pwdata[7:0];
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence read_s(logic [15:0] a);
		setup_s ##0 !pwrite && paddr == a;
	endsequence

	zero_wait_a:
		assert property (setup_s |=> pready) else $error("access phase without ready");
	ready_place_a:
		assert property (pready |-> psel && penable) else $error("ready outside access phase");
	bad_addr_a:
		assert property (setup_s ##0 !mapped |=> pslverr && prdata == '0) else $error("unmapped access accepted");
	good_addr_a:
		assert property (setup_s ##0 mapped |=> !pslverr) else $error("mapped access refused");
	upper_zero_a:
		assert property (pready |-> prdata[31:8] == '0) else $error("upper read bits not zero");
	fixed_bit_a:
		assert property (read_s(TIMER_CONTROL_STATUS_ADDR) |=> prdata[4]) else $error("status bit 4 not one");
	b_gate_a:
		assert property (o_irq.match_b_irq |-> $past(ctl_sh[CTL_MATCH_B_IE_POS])) else $error("match b request ungated");
	a_gate_a:
		assert property (o_irq.match_a_irq |-> $past(ctl_sh[CTL_MATCH_A_IE_POS])) else $error("match a request ungated");
	wrap_gate_a:
		assert property (o_irq.wrap_irq |-> $past(ctl_sh[CTL_WRAP_IE_POS])) else $error("wrap request ungated");
	standby_quiet_a:
		assert property (i_standby ##1 i_standby |=> o_irq == '0 && !o_wave_output_en)
			else $error("activity during standby");
endmodule

bind emt_timer emt_timer_properties emt_timer_properties_inst (.*);

// [tb/emt_xfer_model.sv]
`timescale 1ns/1ps
module emt_xfer_model (
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	input  wire logic              i_enable,
	input  wire emt_pkg::emt_irq_t  i_irq,
	output emt_pkg::emt_xfer_ack_t o_ack
);
	import emt_pkg::*;

	// serve match requests
	// Wrap request is never served here: only software may clear it
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_ack <= '0;
		end else begin
			o_ack.match_a_ack <= i_enable && i_irq.match_a_irq && !o_ack.match_a_ack;
			o_ack.match_b_ack <= i_enable && i_irq.match_b_irq && !o_ack.match_b_ack;
		end
	end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import emt_pkg::*;

	logic          clk, rst, stby, psel, penable, pwrite, ecnt, eclr, xen;
	logic          pready, pslverr, wave, wave_en;
	logic [15:0]   paddr;
	logic [31:0]   pwdata, prdata;
	logic [7:0]    r;
	emt_xfer_ack_t ack;
	emt_irq_t      irq;
	int            err_count, cmp_count;

	emt_timer emt_timer_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_standby(stby), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .i_external_count_input(ecnt), .i_external_clear_input(eclr),
		.i_xfer_ack(ack), .o_irq(irq), .o_wave_output(wave), .o_wave_output_en(wave_en));
	emt_xfer_model emt_xfer_model_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_enable(xen), .i_irq(irq),
		.o_ack(ack));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata[7:0];
		if (n >= 16) err_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(r, e);
	endtask

	// Each toggle is held long enough for single and double edge counting
	task automatic steps(input int n);
		repeat (n) begin
			ecnt <= ~ecnt;
			repeat (4) @(posedge clk);
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic defaults;
		rd(TIMER_CONTROL_ADDR, TIMER_CONTROL_RST);
		rd(TIMER_CONTROL_STATUS_ADDR, STATUS_FIXED_BITS);
		rd(MATCH_CONSTANT_A_ADDR, MATCH_CONSTANT_RST);
		rd(MATCH_CONSTANT_B_ADDR, MATCH_CONSTANT_RST);
		rd(TICK_COUNTER_ADDR, TICK_COUNTER_RST);
		rd(16'hffd6, 8'h00);
		chk({6'h0, wave, wave_en}, 8'h00);
	endtask

	// Prescaler phase is unknown to the bench, so a window of counts is accepted
	task automatic t_div;
		xfer(1'b1, TICK_COUNTER_ADDR, 8'h00);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h02);
		repeat (130) @(posedge clk);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h00);
		xfer(1'b0, TICK_COUNTER_ADDR, 8'h00);
		chk({7'h0, (r >= 8'h02 && r <= 8'h03)}, 8'h01);
		xfer(1'b1, TICK_COUNTER_ADDR, 8'h00);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h03);
		repeat (2100) @(posedge clk);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h00);
		xfer(1'b0, TICK_COUNTER_ADDR, 8'h00);
		chk({7'h0, (r >= 8'h02 && r <= 8'h03)}, 8'h01);
	endtask

	task automatic t_wrap;
		xfer(1'b1, TICK_COUNTER_ADDR, 8'hfe);
		rd(TICK_COUNTER_ADDR, 8'hfe);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'ha1);
		repeat (30) @(posedge clk);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'ha0);
		chk({5'h0, irq}, 8'h05);
		rd(TIMER_CONTROL_STATUS_ADDR, 8'hf0);
		xfer(1'b1, TIMER_CONTROL_STATUS_ADDR, 8'hf0);
		xfer(1'b1, TIMER_CONTROL_STATUS_ADDR, 8'h00);
		rd(TIMER_CONTROL_STATUS_ADDR, 8'hf0);
		xfer(1'b1, TIMER_CONTROL_STATUS_ADDR, 8'h00);
		rd(TIMER_CONTROL_STATUS_ADDR, 8'h10);
		chk({5'h0, irq}, 8'h00);
	endtask

	task automatic t_match;
		xfer(1'b1, TICK_COUNTER_ADDR, 8'h00);
		xfer(1'b1, MATCH_CONSTANT_A_ADDR, 8'h03);
		xfer(1'b1, TIMER_CONTROL_STATUS_ADDR, 8'h03);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h4d);
		steps(8);
		rd(TICK_COUNTER_ADDR, 8'h00);
		chk({6'h0, wave, wave_en}, 8'h03);
		chk({5'h0, irq}, 8'h02);
		xen <= 1'b1;
		repeat (4) @(posedge clk);
		rd(TIMER_CONTROL_STATUS_ADDR, 8'h13);
		xen <= 1'b0;
	endtask

	task automatic t_ext;
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h1f);
		steps(5);
		rd(TICK_COUNTER_ADDR, 8'h05);
		eclr <= 1'b1;
		repeat (4) @(posedge clk);
		eclr <= 1'b0;
		rd(TICK_COUNTER_ADDR, 8'h00);
		xfer(1'b1, TIMER_CONTROL_ADDR, 8'h1e);
		steps(1);
		rd(TICK_COUNTER_ADDR, 8'h01);
	endtask

	task automatic t_standby;
		xfer(1'b1, MATCH_CONSTANT_B_ADDR, 8'h12);
		stby <= 1'b1;
		repeat (3) @(posedge clk);
		stby <= 1'b0;
		defaults();
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim();
	end

	initial begin
		{rst, stby, psel, penable, pwrite, ecnt, eclr, xen} = 8'h80;
		paddr = 16'h0000;
		pwdata = 32'h0;
		err_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		defaults();
		t_wrap();
		t_match();
		t_ext();
		t_standby();
		t_div();
		end_sim();
	end
endmodule
